// file: verilog/ams_monitor.sv
// Sequencer, result trackers, alarms and register file of the analog monitor.
// Assumes converter cores and debug reader run on i_mclk; bus is Avalon-MM.
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps

// Summary of operation
// (R1) Two converters, 12-bit, paced at 1 MSPS
// (R2) Mux selects seventeen external channels or sensors
// (R3) Simultaneous mode starts both converters together
// (R4) Unipolar, bipolar, differential; coding follows type
// (R5) External mux mode uses dedicated input
// (R6) Selectable on-chip or external reference
// (R7) Default mode scans all on-chip sensors
// (R8) Keep newest, maximum and minimum per slot
// (R9) Debug port reads results whenever i_ce is high, no stall
// (R10) Over-temperature and supply band alarms
// (R11) Temperature limit requests automatic power-down
// (R12) Max starts lowest, min starts highest
module ams_monitor
(
  // Clock, reset, enable
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst,
  input  wire logic                       i_ce,
  // Avalon-MM slave
  input  wire logic [7:0]                 i_avs_address,
  input  wire logic                       i_avs_read,
  input  wire logic                       i_avs_write,
  input  wire logic [31:0]                i_avs_writedata,
  input  wire logic [3:0]                 i_avs_byteenable,
  output logic      [31:0]                o_avs_readdata,
  output logic                            o_avs_waitrequest,
  // Converter A
  output logic                            o_conv_a_start,
  output logic      [ams_pkg::SELW-1:0]   o_conv_a_sel,
  input  wire logic                       i_conv_a_done,
  input  wire logic [ams_pkg::DW-1:0]     i_conv_a_data,
  // Converter B
  output logic                            o_conv_b_start,
  output logic      [ams_pkg::SELW-1:0]   o_conv_b_sel,
  input  wire logic                       i_conv_b_done,
  input  wire logic [ams_pkg::DW-1:0]     i_conv_b_data,
  // Analog front-end settings
  output logic      [1:0]                 o_in_type,
  output logic                            o_ref_ext,
  output logic      [ams_pkg::CHW-1:0]    o_ext_mux_addr,
  // Debug read port
  input  wire logic [7:0]                 i_dbg_addr,
  output logic      [31:0]                o_dbg_data,
  // Alarms and interrupt
  output logic                            o_alarm_ot,
  output logic                            o_alarm_sup,
  output logic                            o_pdn_req,
  output logic                            o_irq
);
  import ams_pkg::*;

  logic [CTRLW-1:0] ctrl_r;
  logic [NEVT-1:0]  stat_r;
  logic [NEVT-1:0]  mask_r;
  logic [DW-1:0]    ot_thr_r;
  logic [DW-1:0]    sup_hi_r;
  logic [DW-1:0]    sup_lo_r;
  logic [DW-1:0]    pdn_r;
  logic [DW-1:0]    res_r [NSLOT];
  logic [DW-1:0]    max_r [NSLOT];
  logic [DW-1:0]    min_r [NSLOT];
  logic [NSLOT-1:0] seen_r;
  ams_seq_t         st_r;
  logic [1:0]       sens_r;
  logic [GAPW-1:0]  gap_r;
  logic             pair_r;
  logic             user_r;
  logic             a_got_r;
  logic             b_got_r;
  logic             ack_r;
  logic             bus_req;
  logic             wr_go;
  logic [NSLOT-1:0] wr_en;
  logic [DW-1:0]    wr_val [NSLOT];
  logic             ot_nxt;
  logic             sup_nxt;
  logic             pdn_nxt;
  logic [NEVT-1:0]  evt;
  logic [NEVT-1:0]  stat_nxt;
  ams_in_t          in_type;

  // Channel field limited to the external range
  function automatic logic [CHW-1:0] ch_clip(input logic [CHW-1:0] ch);
    ch_clip = (ch > CHW'(NEXT_CH - 1)) ? CHW'(NEXT_CH - 1) : ch;
  endfunction : ch_clip

  // Byte-lane merge for writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    be_merge = m;
  endfunction : be_merge

  // Result coding per input type for user slots
  function automatic logic [DW-1:0] coded(input int slot, input logic [DW-1:0] raw);
    if (slot >= SLOT_A && (in_type == AMS_IN_BIP || in_type == AMS_IN_DIFF))
    begin
      coded = raw ^ SIGN_FLIP; // R4
    end
    else
    begin
      coded = raw;
    end
  endfunction : coded

  // Shared register read decode for bus and debug port
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h00000000;
    unique case (a)
      ADR_CTRL:   d = 32'(ctrl_r);
      ADR_STAT:   d = 32'(stat_r);
      ADR_MASK:   d = 32'(mask_r);
      ADR_OT_THR: d = 32'(ot_thr_r);
      ADR_SUP_HI: d = 32'(sup_hi_r);
      ADR_SUP_LO: d = 32'(sup_lo_r);
      ADR_PDN:    d = 32'(pdn_r);
      ADR_ALARM:  d = 32'({o_pdn_req, o_alarm_sup, o_alarm_ot, 1'b0});
      default:
      begin
        for (int s = 0; s < NSLOT; s++)
        begin
          if (a == ADR_RES + 8'(s * 4))
          begin
            d = 32'(coded(s, res_r[s])); // R9
          end
          if (a == ADR_MAX + 8'(s * 4))
          begin
            d = 32'(coded(s, max_r[s]));
          end
          if (a == ADR_MIN + 8'(s * 4))
          begin
            d = 32'(coded(s, min_r[s]));
          end
        end
      end
    endcase
    rd_word = d;
  endfunction : rd_word

  assign in_type = ams_in_t'(ctrl_r[CTRL_TYPE_LSB +: 2]);
  assign bus_req = i_avs_read | i_avs_write;
  assign wr_go   = i_ce & i_avs_write & ack_r;
  assign o_avs_waitrequest = bus_req & ~(ack_r & i_ce);

  // Bus handshake: one wait cycle, then answer
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      ack_r          <= 1'b0;
      o_avs_readdata <= 32'h00000000;
    end
    else if (i_ce)
    begin
      ack_r <= bus_req & ~ack_r;
      if (i_avs_read & ~ack_r)
      begin
        o_avs_readdata <= rd_word(i_avs_address);
      end
    end
  end

  // Debug port read, independent of the sequencer
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_dbg_data <= 32'h00000000;
    end
    else if (i_ce)
    begin
      o_dbg_data <= rd_word(i_dbg_addr); // R9
    end
  end

  // Configuration registers
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      ctrl_r   <= CTRL_RST;
      mask_r   <= MASK_RST;
      ot_thr_r <= OT_THR_RST;
      sup_hi_r <= SUP_HI_RST;
      sup_lo_r <= SUP_LO_RST;
      pdn_r    <= PDN_RST;
    end
    else if (wr_go)
    begin
      unique case (i_avs_address)
        ADR_CTRL:   ctrl_r   <= CTRLW'(be_merge(32'(ctrl_r), i_avs_writedata, i_avs_byteenable));
        ADR_MASK:   mask_r   <= NEVT'(be_merge(32'(mask_r), i_avs_writedata, i_avs_byteenable));
        ADR_OT_THR: ot_thr_r <= DW'(be_merge(32'(ot_thr_r), i_avs_writedata, i_avs_byteenable));
        ADR_SUP_HI: sup_hi_r <= DW'(be_merge(32'(sup_hi_r), i_avs_writedata, i_avs_byteenable));
        ADR_SUP_LO: sup_lo_r <= DW'(be_merge(32'(sup_lo_r), i_avs_writedata, i_avs_byteenable));
        ADR_PDN:    pdn_r    <= DW'(be_merge(32'(pdn_r), i_avs_writedata, i_avs_byteenable)); // R11
        default:    ;
      endcase
    end
  end

  // Front-end settings follow control
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_in_type      <= 2'h0;
      o_ref_ext      <= 1'b0;
      o_ext_mux_addr <= 5'h00;
    end
    else if (i_ce)
    begin
      o_in_type      <= ctrl_r[CTRL_TYPE_LSB +: 2]; // R4
      o_ref_ext      <= ctrl_r[CTRL_EXTREF]; // R6
      o_ext_mux_addr <= ch_clip(ctrl_r[CTRL_CHA_LSB +: CHW]); // R5
    end
  end

  // Conversion sequencer
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      st_r           <= AMS_SQ_IDLE;
      sens_r         <= 2'h0;
      gap_r          <= 6'h00;
      pair_r         <= 1'b0;
      user_r         <= 1'b0;
      a_got_r        <= 1'b0;
      b_got_r        <= 1'b0;
      o_conv_a_start <= 1'b0;
      o_conv_b_start <= 1'b0;
      o_conv_a_sel   <= 6'h00;
      o_conv_b_sel   <= 6'h00;
    end
    else if (i_ce)
    begin
      o_conv_a_start <= 1'b0;
      o_conv_b_start <= 1'b0;
      if (gap_r != 6'h00)
      begin
        gap_r <= gap_r - 6'h01;
      end
      unique case (st_r)
        AMS_SQ_IDLE:
        begin
          user_r         <= ctrl_r[CTRL_USER];
          pair_r         <= ctrl_r[CTRL_USER] & ctrl_r[CTRL_SIMUL]; // R3
          o_conv_a_start <= 1'b1; // R1
          o_conv_b_start <= ctrl_r[CTRL_USER] & ctrl_r[CTRL_SIMUL]; // R3
          gap_r          <= GAPW'(SAMPLE_CYC - 1); // R1
          a_got_r        <= 1'b0;
          b_got_r        <= 1'b0;
          if (!ctrl_r[CTRL_USER])
          begin
            o_conv_a_sel <= SEL_SENS_BASE | SELW'(sens_r); // R7
          end
          else if (ctrl_r[CTRL_EXTMUX])
          begin
            o_conv_a_sel <= SEL_DEDICATED; // R5
          end
          else
          begin
            o_conv_a_sel <= SELW'(ch_clip(ctrl_r[CTRL_CHA_LSB +: CHW])); // R2
          end
          o_conv_b_sel <= SELW'(ch_clip(ctrl_r[CTRL_CHB_LSB +: CHW])); // R2
          st_r         <= AMS_SQ_WAIT;
        end
        AMS_SQ_WAIT:
        begin
          a_got_r <= a_got_r | i_conv_a_done;
          b_got_r <= b_got_r | i_conv_b_done;
          if ((a_got_r | i_conv_a_done) && (!pair_r || b_got_r || i_conv_b_done))
          begin
            st_r <= AMS_SQ_GAP;
          end
        end
        AMS_SQ_GAP:
        begin
          if (gap_r == 6'h00)
          begin
            sens_r <= user_r ? 2'h0 : sens_r + 2'h1; // R7
            st_r   <= AMS_SQ_IDLE;
          end
        end
        default: st_r <= AMS_SQ_IDLE;
      endcase
    end
  end

  // Slot write steering
  always_comb
  begin
    for (int s = 0; s < NSLOT; s++)
    begin
      wr_en[s]  = 1'b0;
      wr_val[s] = i_conv_a_data;
    end
    if (st_r == AMS_SQ_WAIT && i_conv_a_done && !a_got_r)
    begin
      if (user_r)
      begin
        wr_en[SLOT_A] = 1'b1;
      end
      else
      begin
        wr_en[sens_r] = 1'b1; // R7
      end
    end
    if (st_r == AMS_SQ_WAIT && pair_r && i_conv_b_done && !b_got_r)
    begin
      wr_en[SLOT_B]  = 1'b1;
      wr_val[SLOT_B] = i_conv_b_data;
    end
  end

  // Newest, maximum and minimum trackers
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      seen_r <= '0;
      for (int s = 0; s < NSLOT; s++)
      begin
        res_r[s] <= MAX_RST;
        max_r[s] <= MAX_RST; // R12
        min_r[s] <= MIN_RST; // R12
      end
    end
    else if (i_ce)
    begin
      for (int s = 0; s < NSLOT; s++)
      begin
        if (wr_en[s])
        begin
          seen_r[s] <= 1'b1;
          res_r[s]  <= wr_val[s]; // R8
          if (wr_val[s] > max_r[s])
          begin
            max_r[s] <= wr_val[s]; // R8
          end
          if (wr_val[s] < min_r[s])
          begin
            min_r[s] <= wr_val[s]; // R8
          end
        end
      end
    end
  end

  // Alarm comparisons
  always_comb
  begin
    ot_nxt  = seen_r[SLOT_TEMP] && (res_r[SLOT_TEMP] > ot_thr_r); // R10
    pdn_nxt = seen_r[SLOT_TEMP] && (res_r[SLOT_TEMP] > pdn_r); // R11
    sup_nxt = 1'b0;
    for (int s = SLOT_SUP0; s < NSENS; s++)
    begin
      if (seen_r[s] && (res_r[s] > sup_hi_r || res_r[s] < sup_lo_r))
      begin
        sup_nxt = 1'b1; // R10
      end
    end
  end

  assign evt[ST_EOC] = |wr_en;
  assign evt[ST_OT]  = ot_nxt & ~o_alarm_ot;
  assign evt[ST_SUP] = sup_nxt & ~o_alarm_sup;
  assign evt[ST_PDN] = pdn_nxt & ~o_pdn_req;

  // Set wins over write-one-to-clear
  always_comb
  begin
    stat_nxt = stat_r;
    if (wr_go && i_avs_address == ADR_STAT && i_avs_byteenable[0])
    begin
      stat_nxt = stat_r & ~i_avs_writedata[NEVT-1:0];
    end
    stat_nxt = stat_nxt | evt;
  end

  // Alarm outputs, status and interrupt
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_alarm_ot  <= 1'b0;
      o_alarm_sup <= 1'b0;
      o_pdn_req   <= 1'b0;
      stat_r      <= '0;
      o_irq       <= 1'b0;
    end
    else if (i_ce)
    begin
      o_alarm_ot  <= ot_nxt; // R10
      o_alarm_sup <= sup_nxt; // R10
      o_pdn_req   <= pdn_nxt; // R11
      stat_r      <= stat_nxt;
      o_irq       <= |(stat_nxt & mask_r);
    end
  end
endmodule : ams_monitor

// file: include/ams_pkg.sv
// Constants, register map and types of the analog monitor sequencer.
// Assumes a single 50 MHz clock shared by bus, converters and debug port.
package ams_pkg;
  localparam int DW            = 12;
  localparam int NSLOT         = 6;
  localparam int NSENS         = 4;
  localparam int SLOT_TEMP     = 0;
  localparam int SLOT_SUP0     = 1;
  localparam int SLOT_A        = 4;
  localparam int SLOT_B        = 5;
  localparam int SELW          = 6;
  localparam int CHW           = 5;
  localparam int NEXT_CH       = 17;
  localparam logic [SELW-1:0] SEL_SENS_BASE = 6'h20;
  localparam logic [SELW-1:0] SEL_DEDICATED = 6'h00;
  // Byte addresses on the register bus
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STAT   = 8'h04;
  localparam logic [7:0] ADR_MASK   = 8'h08;
  localparam logic [7:0] ADR_OT_THR = 8'h0C;
  localparam logic [7:0] ADR_SUP_HI = 8'h10;
  localparam logic [7:0] ADR_SUP_LO = 8'h14;
  localparam logic [7:0] ADR_PDN    = 8'h18;
  localparam logic [7:0] ADR_ALARM  = 8'h1C;
  localparam logic [7:0] ADR_RES    = 8'h40;
  localparam logic [7:0] ADR_MAX    = 8'h60;
  localparam logic [7:0] ADR_MIN    = 8'h80;
  // Control fields
  localparam int CTRL_USER     = 0;
  localparam int CTRL_SIMUL    = 1;
  localparam int CTRL_EXTMUX   = 2;
  localparam int CTRL_EXTREF   = 3;
  localparam int CTRL_TYPE_LSB = 4;
  localparam int CTRL_CHA_LSB  = 8;
  localparam int CTRL_CHB_LSB  = 16;
  localparam int CTRLW         = 21;
  // Status, mask and alarm bits
  localparam int ST_EOC  = 0;
  localparam int ST_OT   = 1;
  localparam int ST_SUP  = 2;
  localparam int ST_PDN  = 3;
  localparam int NEVT    = 4;
  // Reset values
  localparam logic [CTRLW-1:0] CTRL_RST   = 21'h000000;
  localparam logic [NEVT-1:0]  MASK_RST   = 4'h0;
  localparam logic [DW-1:0]    OT_THR_RST = 12'hC00;
  localparam logic [DW-1:0]    SUP_HI_RST = 12'hE00;
  localparam logic [DW-1:0]    SUP_LO_RST = 12'h200;
  localparam logic [DW-1:0]    PDN_RST    = 12'hD00;
  localparam logic [DW-1:0]    MAX_RST    = 12'h000;
  localparam logic [DW-1:0]    MIN_RST    = 12'hFFF;
  localparam logic [DW-1:0]    SIGN_FLIP  = 12'h800;
  // Timing
  localparam int CLK_MHZ    = 50;
  localparam int SAMPLE_NS  = 1000;
  localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int GAPW       = 6;

  typedef enum logic [1:0] {AMS_IN_UNI, AMS_IN_BIP, AMS_IN_DIFF, AMS_IN_RSV} ams_in_t;
  typedef enum logic [1:0] {AMS_SQ_IDLE, AMS_SQ_WAIT, AMS_SQ_GAP} ams_seq_t;
endpackage : ams_pkg

// file: sim/ams_chk_monitor.sv
// Port checks of the analog monitor sequencer.
// Assumes a bind onto ams_monitor; clock enable drops only between starts.
`timescale 1ns/1ps
module ams_chk
(
  // Clock, reset
  input wire logic                     i_mclk,
  input wire logic                     i_rst,
  // Bus
  input wire logic                     i_avs_read,
  input wire logic                     i_avs_write,
  input wire logic                     o_avs_waitrequest,
  // Converters, debug, interrupt
  input wire logic                     o_conv_a_start,
  input wire logic [ams_pkg::SELW-1:0] o_conv_a_sel,
  input wire logic                     o_conv_b_start,
  input wire logic [7:0]               i_dbg_addr,
  input wire logic [31:0]              o_dbg_data,
  input wire logic                     o_irq
);
  import ams_pkg::*;
  logic [6:0] gap_r;
  always_ff @(posedge i_mclk)
  begin
    if (i_rst) gap_r <= 7'h7F;
    else if (o_conv_a_start) gap_r <= 7'h01;
    else if (gap_r != 7'h7F) gap_r <= gap_r + 7'h01;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_req_up;
    $rose(i_avs_read) || $rose(i_avs_write);
  endsequence
  sequence s_one_wait;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  chk_bus_wait: assert property (s_req_up |-> s_one_wait)
    else $error("bus wait not one cycle");
  chk_start_gap: assert property (o_conv_a_start |-> gap_r >= 7'h32)
    else $error("starts too close");
  chk_start_pulse: assert property (o_conv_a_start |=> !o_conv_a_start)
    else $error("start too long");
  chk_pair_start: assert property (o_conv_b_start |-> o_conv_a_start)
    else $error("B started alone");
  chk_sel_range: assert property (o_conv_a_start |-> o_conv_a_sel < 6'h11 ||
    (o_conv_a_sel >= SEL_SENS_BASE && o_conv_a_sel < SEL_SENS_BASE + 6'h04))
    else $error("select out of range");
  chk_sel_hold: assert property (!o_conv_a_start |-> $stable(o_conv_a_sel))
    else $error("select moved");
  chk_dbg_unmap: assert property (i_dbg_addr == 8'h3C |=> o_dbg_data == 32'h0)
    else $error("debug unmapped not zero");
  chk_rst_quiet: assert property (disable iff (1'b0) i_rst |=> !o_conv_a_start && !o_irq)
    else $error("active in reset");
endmodule : ams_chk

bind ams_monitor ams_chk u_chk
(
  .i_mclk, .i_rst, .i_avs_read, .i_avs_write, .o_avs_waitrequest, .o_conv_a_start,
  .o_conv_a_sel, .o_conv_b_start, .i_dbg_addr, .o_dbg_data, .o_irq
);

// file: sim/ams_conv_model.sv
// Converter partner: answers a start after a set delay.
// Assumes the sequencer clock and one-cycle start pulses.
`timescale 1ns/1ps
module ams_conv_model
(
  // Control
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic [7:0]  i_dly,
  input  wire logic [11:0] i_val,
  // Result
  output logic             o_done,
  output logic [11:0]      o_data
);
  logic [7:0] cnt_r;
  logic       busy_r;
  always_ff @(posedge i_mclk)
  begin
    o_done <= 1'b0;
    o_data <= i_rst ? 12'h000 : ~o_data;
    if (i_rst) busy_r <= 1'b0;
    else if (i_start)
    begin
      busy_r <= 1'b1;
      cnt_r  <= i_dly;
    end
    else if (busy_r && cnt_r == 8'h00)
    begin
      busy_r <= 1'b0;
      o_done <= 1'b1;
      o_data <= i_val;
    end
    else cnt_r <= cnt_r - 8'h01;
  end
endmodule : ams_conv_model

// file: sim/tb.sv
// Self-checking bench of the analog monitor sequencer.
// Assumes two converter models and a 50 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e, m) \
  begin \
    num_checks++; \
    if ((g) !== (e)) $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e); \
    if ((g) !== (e)) mismatches++; \
  end
module tb;
  import ams_pkg::*;
  typedef struct packed {logic [11:0] v; logic ot; logic sup; logic pdn;} ams_row_t;
  logic        i_mclk, i_rst, i_ce, i_avs_read, i_avs_write, o_avs_waitrequest;
  logic [3:0]  i_avs_byteenable;
  logic [7:0]  i_avs_address, i_dbg_addr, dly_a, dly_b;
  logic [31:0] i_avs_writedata, o_avs_readdata, o_dbg_data, q;
  logic        o_conv_a_start, o_conv_b_start, i_conv_a_done, i_conv_b_done;
  logic [5:0]  o_conv_a_sel, o_conv_b_sel;
  logic [11:0] i_conv_a_data, i_conv_b_data, val_a, val_b;
  logic [1:0]  o_in_type;
  logic [4:0]  o_ext_mux_addr;
  logic        o_ref_ext, o_alarm_ot, o_alarm_sup, o_pdn_req, o_irq;
  int          mismatches = 0;
  int          num_checks = 0;
  ams_row_t    rows [4] = '{'{12'h800, 1'b0, 1'b0, 1'b0}, '{12'hC80, 1'b1, 1'b0, 1'b0},
                            '{12'hE80, 1'b1, 1'b1, 1'b1}, '{12'h100, 1'b0, 1'b1, 1'b0}};

  ams_monitor dut (.*);
  ams_conv_model u_conv_a (.i_mclk, .i_rst, .i_start(o_conv_a_start), .i_dly(dly_a),
    .i_val(val_a), .o_done(i_conv_a_done), .o_data(i_conv_a_data));
  ams_conv_model u_conv_b (.i_mclk, .i_rst, .i_start(o_conv_b_start), .i_dly(dly_b),
    .i_val(val_b), .o_done(i_conv_b_done), .o_data(i_conv_b_data));

  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_avs_address   <= a;
    i_avs_writedata <= d;
    i_avs_write     <= wr;
    i_avs_read      <= !wr;
    @(posedge i_mclk);
    while (o_avs_waitrequest !== 1'b0)
    begin
      @(posedge i_mclk);
    end
    q = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_mclk);
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e, "register read")
  endtask : rd_chk

  task automatic wait_starts(input int k);
    while (k > 0)
    begin
      @(negedge i_mclk);
      if (o_conv_a_start === 1'b1) k--;
    end
  endtask : wait_starts

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (20000) @(posedge i_mclk);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    {i_rst, i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} <= {1'b1, 42'h0};
    {i_dbg_addr, val_a, val_b, dly_a, dly_b} <= {8'h3C, 12'h800, 12'h000, 8'h14, 8'h05};
    {i_ce, i_avs_byteenable} <= {1'b1, 4'hF};
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    foreach (rows[i])
    begin
      val_a <= rows[i].v;
      wait_starts(5);
      @(posedge i_mclk);
      for (int s = 0; s < 4 * NSENS; s += 4) rd_chk(ADR_RES + 8'(s), {20'h0, rows[i].v});
      `CHK({o_alarm_ot, o_alarm_sup, o_pdn_req}, {rows[i].ot, rows[i].sup, rows[i].pdn}, "alarm")
      rd_chk(ADR_ALARM, {28'h0, rows[i].pdn, rows[i].sup, rows[i].ot, 1'b0});
    end
    rd_chk(ADR_MAX, 32'hE80);
    rd_chk(ADR_MIN, 32'h100);
    `CHK(o_irq, 1'b0, "irq masked")
    bus(1'b1, ADR_MASK, 32'h2);
    repeat (2) @(negedge i_mclk);
    `CHK(o_irq, 1'b1, "irq raised")
    @(posedge i_mclk);
    bus(1'b1, ADR_STAT, 32'h2);
    repeat (2) @(negedge i_mclk);
    `CHK(o_irq, 1'b0, "irq cleared")
    @(posedge i_mclk);
    rd_chk(ADR_STAT, 32'hD);
    bus(1'b1, 8'h3C, 32'hFFFFFFFF);
    rd_chk(8'h3C, 32'h0);
    i_dbg_addr <= ADR_RES + 8'h14;
    val_a      <= 12'h123;
    val_b      <= 12'hF00;
    bus(1'b1, ADR_CTRL, 32'h0007031B);
    wait_starts(3);
    `CHK({o_conv_a_sel, o_conv_b_sel, o_in_type, o_ref_ext}, {6'h03, 6'h07, 2'h1, 1'b1}, "mode")
    `CHK(o_dbg_data, 32'h700, "debug read")
    @(posedge i_mclk);
    rd_chk(ADR_RES + 8'h10, 32'h923);
    rd_chk(ADR_RES + 8'h14, 32'h700);
    rd_chk(ADR_CTRL, 32'h0007031B);
    dly_a <= 8'h50;
    bus(1'b1, ADR_CTRL, 32'h00001405);
    wait_starts(2);
    `CHK({o_ext_mux_addr, o_conv_a_sel}, {5'h10, SEL_DEDICATED}, "ext mux")
    @(posedge i_mclk);
    i_ce       <= 1'b0;
    i_dbg_addr <= ADR_OT_THR;
    repeat (4) @(negedge i_mclk);
    `CHK(o_dbg_data, 32'hF00, "frozen debug")
    @(posedge i_mclk);
    i_ce <= 1'b1;
    repeat (2) @(negedge i_mclk);
    `CHK(o_dbg_data, {20'h0, OT_THR_RST}, "debug after freeze")
    @(posedge i_mclk);
    i_avs_byteenable <= 4'h1;
    bus(1'b1, ADR_OT_THR, 32'hFFFFFFAB);
    rd_chk(ADR_OT_THR, 32'hCAB);
    i_avs_byteenable <= 4'hF;
    bus(1'b1, ADR_CTRL, 32'h00000021);
    rd_chk(ADR_RES + 8'h14, 32'h700);
    `CHK(o_in_type, 2'h2, "diff type")
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    rd_chk(ADR_MAX, 32'h0);
    rd_chk(ADR_MIN, 32'hFFF);
    rd_chk(ADR_OT_THR, {20'h0, OT_THR_RST});
    rd_chk(ADR_PDN, {20'h0, PDN_RST});
    give_verdict();
  end
endmodule : tb
